// File: ext_pattern_gen.sv
// 100M one-plus-zeros repetitive pattern generator
`timescale 1ns/10ps
module ext_pattern_gen #(
	parameter int ZERO_W = phy_test_pkg::ZC_W,
	parameter int DIV = phy_test_pkg::BIT_DIV
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic restart_i,
	// control
	input wire logic enable_i,
	input wire logic [ZERO_W-1:0] zero_count_i,
	// serial pattern
	output logic bit_o
);
	logic [7:0] div_cnt; // bit-rate divider
	logic tick; // one pattern bit time
	logic [ZERO_W-1:0] zeros_left; // zeros still to send

	// bit-rate enable pulse
	always_ff @(posedge clk_i) begin
		if (rst_i || restart_i || !enable_i) begin
			div_cnt <= 8'h00;
			tick <= 1'b0;
		end else if (div_cnt == 8'(DIV - 1)) begin
			div_cnt <= 8'h00;
			tick <= 1'b1;
		end else begin
			div_cnt <= div_cnt + 8'h01;
			tick <= 1'b0;
		end
	end

	// shifter: a one, then the programmed zeros
	always_ff @(posedge clk_i) begin
		if (rst_i || restart_i || !enable_i) begin
			zeros_left <= '0;
			bit_o <= 1'b0;
		end else if (zero_count_i == '0) begin
			zeros_left <= '0;
			bit_o <= 1'b0;
		end else if (tick) begin
			if (zeros_left == '0) begin
				bit_o <= 1'b1;
				zeros_left <= zero_count_i;
			end else begin
				bit_o <= 1'b0;
				zeros_left <= zeros_left - 1'b1;
			end
		end
	end
endmodule

// File: pattern_monitor.sv
// receiving-end model that times the one-plus-zeros test pattern
`timescale 1ns/10ps
module pattern_monitor (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// pattern as seen on the line
	input wire logic bit_i,
	input wire logic enable_i,
	// measured figures
	output logic [7:0] period_o,
	output logic [7:0] rises_o
);
	logic [7:0] gap; // cycles since the last one
	logic last; // previous line level
	// time each repeat of the one by its rising edges
	always_ff @(posedge clk_i) begin
		last <= bit_i;
		if (rst_i || !enable_i) begin
			gap <= 8'h00;
			rises_o <= 8'h00;
		end else if (bit_i && !last) begin
			period_o <= gap;
			gap <= 8'h01;
			rises_o <= (rises_o == 8'hFF) ? rises_o : rises_o + 8'h01;
		end else begin
			gap <= gap + 8'h01;
		end
	end
endmodule

// File: phy_test_ctrl.sv
// soft reset, soft restart and transmit test pattern control with wishbone access
//
// The Wishbone slave port was left to the implementer.
`timescale 1ns/10ps
module phy_test_ctrl (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// straps
	input wire logic [phy_test_pkg::STRAP_W-1:0] strap_i,
	output logic [phy_test_pkg::STRAP_W-1:0] strap_config_o,
	// transceiver reset and restart
	output logic phy_reset_o,
	output logic phy_restart_o,
	// 100M extended pattern
	output logic ext_enable_o,
	output logic ext_bit_o,
	output logic [2:0] pulse_level_o,
	output logic [3:0] channel_mask_o,
	// 10BASE-T pattern
	output logic tenbt_enable_o,
	output logic [3:0] tenbt_code_o,
	output phy_test_pkg::tenbt_kind_t tenbt_kind_o
);
	import phy_test_pkg::*;

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic full_soft_reset; // bit 15, self clearing
	logic soft_restart; // bit 14, self clearing
	logic [13:0] gen_spare; // plain read/write bits
	logic [1:0] mode7_pulse_select; // amplitude and polarity
	logic ext_pattern_zero_count_msb; // zero count msb
	logic ext_pattern_100m_enable; // extended pattern on
	logic [2:0] pattern_channel_select; // all flag plus channel
	logic [4:0] test_field; // 10BASE-T enable and code
	logic [STRAP_W-1:0] strap_latched; // last captured straps
	logic strap_taken; // straps captured since reset
	logic [STRAP_W-1:0] strap_config; // strap-backed field
	seq_state_t state; // sequencer state
	logic [SEQ_CNT_W-1:0] seq_cnt; // sequencer countdown
	logic wipe; // one-cycle register restore
	logic seq_done; // last cycle of a sequence
	logic run; // normal operation
	logic req; // bus request present
	logic wr_fire; // write takes effect
	logic [5:0] idx; // register index
	logic [15:0] wmask; // byte lane mask
	logic [15:0] gen_rd; // general control image
	logic [15:0] pat_rd; // pattern control image
	logic [15:0] gen_new; // merged write value
	logic [15:0] pat_new; // merged write value
	logic [15:0] strap_new; // merged write value
	logic [15:0] next_rdata; // read mux result
	logic [ZC_W-1:0] zero_count; // assembled zero count
	logic gen_active; // generator enable
	logic restart_pulse; // restart for generator

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	assign req = wb_cyc_i && wb_stb_i;
	assign idx = wb_adr_i[7:2];
	assign wr_fire = req && wb_we_i && wb_ack_o;
	assign wmask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign run = (state == ST_RUN);
	assign seq_done = (state != ST_RUN) && (seq_cnt == '0);
	assign wipe = run && full_soft_reset;

	// register images
	assign gen_rd = {full_soft_reset, soft_restart, gen_spare};
	assign pat_rd = {4'h0, mode7_pulse_select, ext_pattern_zero_count_msb,
		ext_pattern_100m_enable, pattern_channel_select, test_field};

	// byte-lane merge of write data
	assign gen_new = (gen_rd & ~wmask) | (wb_dat_i[15:0] & wmask);
	assign pat_new = (pat_rd & ~wmask) | (wb_dat_i[15:0] & wmask);
	assign strap_new = ({{(16 - STRAP_W){1'b0}}, strap_config} & ~wmask) | (wb_dat_i[15:0] & wmask);

	// read mux, unmapped reads return zero
	always_comb begin
		next_rdata = 16'h0000;
		case (idx)
			IDX_GENERAL_CONTROL: begin
				next_rdata = gen_rd;
			end
			IDX_PATTERN_CONTROL: begin
				next_rdata = pat_rd;
			end
			IDX_STRAP_CONFIG: begin
				next_rdata = {{(16 - STRAP_W){1'b0}}, strap_config};
			end
			default: begin
				next_rdata = 16'h0000;
			end
		endcase
	end

	// ----------------------------------------
	// wishbone answer
	// ----------------------------------------
	// one wait state, ack drops after one cycle
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= req && !wb_ack_o;
		end
	end

	// read data captured with the ack
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= 32'h00000000;
		end else if (req && !wb_ack_o) begin
			wb_dat_o <= {16'h0000, next_rdata};
		end
	end

	// ----------------------------------------
	// strap capture
	// ----------------------------------------
	// straps sampled once in the first clock after reset release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_taken <= 1'b0;
			strap_latched <= '0;
		end else if (!strap_taken) begin
			strap_taken <= 1'b1;
			strap_latched <= strap_i;
		end
	end

	// strap-backed field, reloaded from the latched straps on full soft reset
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_config <= '0;
		end else if (!strap_taken) begin
			strap_config <= strap_i;
		end else if (wipe) begin
			strap_config <= strap_latched;
		end else if (wr_fire && idx == IDX_STRAP_CONFIG) begin
			strap_config <= strap_new[STRAP_W-1:0];
		end
	end

	// ----------------------------------------
	// general control register
	// ----------------------------------------
	// reset request: set by software, cleared when sequence ends
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			full_soft_reset <= GENERAL_CONTROL_RST[FULL_RESET_BIT];
		end else if (wr_fire && idx == IDX_GENERAL_CONTROL && gen_new[FULL_RESET_BIT]) begin
			full_soft_reset <= 1'b1; // set wins over clear
		end else if (seq_done && state == ST_FULL_RESET) begin
			full_soft_reset <= 1'b0;
		end
	end

	// restart request: cleared when its sequence ends
	always_ff @(posedge clk_i) begin
		if (rst_i || wipe) begin
			soft_restart <= GENERAL_CONTROL_RST[SOFT_RESTART_BIT];
		end else if (wr_fire && idx == IDX_GENERAL_CONTROL && gen_new[SOFT_RESTART_BIT]) begin
			soft_restart <= 1'b1;
		end else if (seq_done && state == ST_RESTART) begin
			soft_restart <= 1'b0;
		end
	end

	// spare read/write bits
	always_ff @(posedge clk_i) begin
		if (rst_i || wipe) begin
			gen_spare <= GENERAL_CONTROL_RST[13:0];
		end else if (wr_fire && idx == IDX_GENERAL_CONTROL) begin
			gen_spare <= gen_new[13:0];
		end
	end

	// ----------------------------------------
	// pattern control register
	// ----------------------------------------
	// restart leaves these alone, full reset restores them
	always_ff @(posedge clk_i) begin
		if (rst_i || wipe) begin
			mode7_pulse_select <= PATTERN_CONTROL_RST[PULSE_SEL_LSB +: 2];
			ext_pattern_zero_count_msb <= PATTERN_CONTROL_RST[ZC_MSB_BIT];
			ext_pattern_100m_enable <= PATTERN_CONTROL_RST[EXT_EN_BIT];
			pattern_channel_select <= PATTERN_CONTROL_RST[CH_SEL_LSB +: 3];
			test_field <= PATTERN_CONTROL_RST[4:0];
		end else if (wr_fire && idx == IDX_PATTERN_CONTROL) begin
			mode7_pulse_select <= pat_new[PULSE_SEL_LSB +: 2];
			ext_pattern_zero_count_msb <= pat_new[ZC_MSB_BIT];
			ext_pattern_100m_enable <= pat_new[EXT_EN_BIT];
			pattern_channel_select <= pat_new[CH_SEL_LSB +: 3];
			test_field <= pat_new[4:0];
		end
	end

	// ----------------------------------------
	// reset and restart sequencer
	// ----------------------------------------
	// full reset outranks restart when both are requested
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state <= ST_RUN;
			seq_cnt <= '0;
		end else begin
			case (state)
				ST_RUN: begin
					if (full_soft_reset) begin
						state <= ST_FULL_RESET;
						seq_cnt <= SEQ_CNT_W'(RESET_HOLD_CYC - 1);
					end else if (soft_restart) begin
						state <= ST_RESTART;
						seq_cnt <= SEQ_CNT_W'(RESTART_HOLD_CYC - 1);
					end
				end
				ST_FULL_RESET, ST_RESTART: begin
					if (seq_cnt == '0) begin
						state <= ST_RUN;
					end else begin
						seq_cnt <= seq_cnt - 1'b1;
					end
				end
				default: begin
					state <= ST_RUN;
				end
			endcase
		end
	end

	// transceiver reset and restart levels
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			phy_reset_o <= 1'b0;
			phy_restart_o <= 1'b0;
		end else begin
			phy_reset_o <= (state == ST_FULL_RESET);
			phy_restart_o <= (state != ST_RUN);
		end
	end

	// ----------------------------------------
	// 100M extended pattern
	// ----------------------------------------
	assign zero_count = {ext_pattern_zero_count_msb, test_field[3:0]};
	assign gen_active = run && ext_pattern_100m_enable;
	assign restart_pulse = !run;

	// pattern shifter
	ext_pattern_gen #(
		.ZERO_W(ZC_W),
		.DIV(BIT_DIV)
	) u_gen (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.restart_i(restart_pulse),
		.enable_i(gen_active),
		.zero_count_i(zero_count),
		.bit_o(ext_bit_o)
	);

	// extended pattern enable output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_enable_o <= 1'b0;
		end else begin
			ext_enable_o <= gen_active;
		end
	end

	// ----------------------------------------
	// pulse amplitude and channel steering
	// ----------------------------------------
	// mode 7 pulse level
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pulse_level_o <= LEVEL_M2;
		end else begin
			case (mode7_pulse_select)
				2'h0: begin
					pulse_level_o <= LEVEL_P2;
				end
				2'h1: begin
					pulse_level_o <= LEVEL_M2;
				end
				2'h2: begin
					pulse_level_o <= LEVEL_P1;
				end
				default: begin
					pulse_level_o <= LEVEL_M1;
				end
			endcase
		end
	end

	// channel mask, bit 0 is channel A
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			channel_mask_o <= 4'hF;
		end else if (pattern_channel_select[2]) begin
			channel_mask_o <= 4'hF;
		end else begin
			channel_mask_o <= 4'h1 << pattern_channel_select[1:0];
		end
	end

	// ----------------------------------------
	// 10BASE-T pattern
	// ----------------------------------------
	// code to pattern kind
	function automatic tenbt_kind_t kind_of(input logic [3:0] code);
		tenbt_kind_t k;
		k = K_NONE;
		case (code)
			4'h0: k = K_LINK_PULSE;
			4'h1: k = K_PULSE_ONE;
			4'h2: k = K_PULSE_ZERO;
			4'h3: k = K_REP_ONE;
			4'h4: k = K_REP_ZERO;
			4'h5: k = K_PREAMBLE;
			4'h6: k = K_ONE_IDLE;
			4'h7: k = K_ZERO_IDLE;
			4'h8: k = K_SEQ_1001;
			4'h9: k = K_RANDOM;
			4'hA, 4'hB, 4'hC, 4'hD: k = K_IDLE_VARIANT;
			default: k = K_NONE;
		endcase
		return k;
	endfunction

	// 10BASE-T enable, code and kind
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			tenbt_enable_o <= 1'b0;
			tenbt_code_o <= 4'h0;
			tenbt_kind_o <= K_NONE;
		end else begin
			tenbt_enable_o <= run && test_field[TENBT_EN_BIT];
			tenbt_code_o <= test_field[3:0];
			tenbt_kind_o <= (run && test_field[TENBT_EN_BIT]) ? kind_of(test_field[3:0]) : K_NONE;
		end
	end

	// strap-backed field output
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			strap_config_o <= '0;
		end else begin
			strap_config_o <= strap_config;
		end
	end
endmodule

// File: phy_test_ctrl_props.sv
// checker for the reset and test pattern control block
`timescale 1ns/10ps
module phy_test_ctrl_props (
	// clock, reset and bus
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// transceiver controls
	input wire logic phy_reset_o,
	input wire logic phy_restart_o,
	input wire logic ext_enable_o,
	input wire logic ext_bit_o,
	input wire logic [2:0] pulse_level_o,
	input wire logic [3:0] channel_mask_o,
	input wire logic tenbt_enable_o,
	input wire logic [3:0] tenbt_code_o,
	input phy_test_pkg::tenbt_kind_t tenbt_kind_o
);
	import phy_test_pkg::*;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [7:0] hold_rst; // cycles with full reset high
	logic [7:0] hold_rs; // cycles with restart high
	logic was_full; // a full reset lay inside this restart
	logic wr_pat; // pattern register written
	logic [15:0] last_pat; // last pattern value written
	assign wr_pat = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h94 && wb_sel_i[1:0] == 2'h3;
	// sequence length counters
	always_ff @(posedge clk_i) begin
		hold_rst <= (rst_i || !phy_reset_o) ? 8'h00 : hold_rst + 8'h01;
		hold_rs <= (rst_i || !phy_restart_o) ? 8'h00 : hold_rs + 8'h01;
		was_full <= (rst_i || !phy_restart_o) ? 1'b0 : (was_full | phy_reset_o);
	end
	// shadow of the pattern register
	always_ff @(posedge clk_i) begin
		if (wr_pat) begin
			last_pat <= wb_dat_i[15:0];
		end
	end
	function automatic logic [2:0] lvl(input logic [1:0] s);
		return s[1] ? (s[0] ? LEVEL_M1 : LEVEL_P1) : (s[0] ? LEVEL_M2 : LEVEL_P2);
	endfunction
	function automatic tenbt_kind_t kind_of(input logic [3:0] c);
		return c > 4'hD ? K_NONE : (c > 4'h9 ? K_IDLE_VARIANT : tenbt_kind_t'(c + 4'h1));
	endfunction
	sequence req_s;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence gen_wr_s;
		wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == 8'h7C && wb_sel_i[1];
	endsequence
	sequence pat_wr_s;
		wr_pat && !phy_restart_o;
	endsequence
	ack_follows_a: assert property (req_s |=> wb_ack_o) else $error("no ack after request");
	ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
	reset_start_a: assert property (gen_wr_s ##0 wb_dat_i[15] |-> ##[1:3] phy_reset_o)
		else $error("full reset did not start");
	reset_len_a: assert property ($fell(phy_reset_o) |-> hold_rst == RESET_HOLD_CYC)
		else $error("full reset length wrong");
	restart_start_a: assert property (gen_wr_s ##0 (wb_dat_i[14] && !wb_dat_i[15]) |-> ##[1:3] phy_restart_o)
		else $error("restart did not start");
	restart_len_a: assert property ($fell(phy_restart_o) && !was_full |-> hold_rs == RESTART_HOLD_CYC)
		else $error("restart length wrong");
	reset_restart_a: assert property (phy_reset_o |-> phy_restart_o) else $error("reset without restart");
	level_map_a: assert property (pat_wr_s |-> ##2 pulse_level_o == lvl(last_pat[11:10]))
		else $error("pulse level wrong");
	mask_map_a: assert property (pat_wr_s |-> ##2 channel_mask_o == (last_pat[7] ? 4'hF : 4'h1 << last_pat[6:5]))
		else $error("channel mask wrong");
	kind_map_a: assert property (tenbt_kind_o == (tenbt_enable_o ? kind_of(tenbt_code_o) : K_NONE))
		else $error("pattern kind wrong");
	pattern_rise_a: assert property ($rose(ext_bit_o) |-> $past(ext_enable_o))
		else $error("pattern one while disabled");
endmodule
bind phy_test_ctrl phy_test_ctrl_props props (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .phy_reset_o, .phy_restart_o, .ext_enable_o, .ext_bit_o,
	.pulse_level_o, .channel_mask_o, .tenbt_enable_o, .tenbt_code_o, .tenbt_kind_o);

// File: phy_test_ctrl_tb.sv
// self-checking bench for the reset and test pattern control block
`timescale 1ns/10ps
module phy_test_ctrl_tb;
	import phy_test_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'h0;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] strap_i = 4'hA;
	logic [31:0] wb_dat_o, rd;
	logic wb_ack_o, phy_reset_o, phy_restart_o, ext_enable_o, ext_bit_o, tenbt_enable_o;
	logic [3:0] strap_config_o, channel_mask_o, tenbt_code_o;
	logic [2:0] pulse_level_o;
	tenbt_kind_t tenbt_kind_o;
	logic [7:0] period, rises;
	logic [7:0] seed = 8'h09; // random source state
	int num_errors = 0;
	int samples_checked = 0;
	int cycles = 0;
	always #2.5 clk_i = ~clk_i;
	phy_test_ctrl dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .strap_i, .strap_config_o, .phy_reset_o, .phy_restart_o, .ext_enable_o,
		.ext_bit_o, .pulse_level_o, .channel_mask_o, .tenbt_enable_o, .tenbt_code_o, .tenbt_kind_o);
	pattern_monitor far_end (.clk_i, .rst_i, .bit_i(ext_bit_o), .enable_i(ext_enable_o), .period_o(period),
		.rises_o(rises));
	// expectation helpers
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	function automatic logic [2:0] exp_level(input logic [1:0] s);
		logic [2:0] t [4] = '{LEVEL_P2, LEVEL_M2, LEVEL_P1, LEVEL_M1};
		return t[s];
	endfunction
	function automatic tenbt_kind_t exp_kind(input logic [3:0] c);
		return c > 4'hD ? K_NONE : (c > 4'h9 ? K_IDLE_VARIANT : tenbt_kind_t'(c + 4'h1));
	endfunction
	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk_kind(input string what, input tenbt_kind_t exp, input tenbt_kind_t got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch %s expected %0d seen %0d", what, exp, got);
		end
	endtask
	// one classic wishbone cycle, result in rd
	task automatic wb(input logic we, input logic [7:0] adr, input logic [15:0] dat);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'h3;
		wb_dat_i <= {16'h0000, dat};
		// wait for the ack, the hang guard stops the run if the ack never comes
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic settle;
		repeat (3) @(posedge clk_i);
	endtask
	// wait out a reset or restart, len = cycles high
	task automatic wait_seq(output int len);
		int n;
		n = 0;
		len = 0;
		while (phy_restart_o !== 1'b1 && n < 10) begin
			@(posedge clk_i);
			n++;
		end
		while (phy_restart_o === 1'b1 && len < 200) begin
			@(posedge clk_i);
			len++;
		end
	endtask
	// load one zero-run value and time the pattern
	task automatic run_ext(input logic [4:0] z);
		int n;
		n = 0;
		wb(1'b1, 8'h94, 16'h0000);
		wb(1'b1, 8'h00, 16'h2000);
		wb(1'b1, 8'h94, {6'h00, z[4], 1'b1, 3'h4, 1'b0, z[3:0]});
		settle();
		chk("ext_enable", 1, ext_enable_o);
		if (z != 5'h00) begin
			while (rises < 8'h03 && n < 400) begin
				@(posedge clk_i);
				n++;
			end
			chk("ext_period", 2 * (z + 1), period);
		end else begin
			repeat (80) @(posedge clk_i) n += int'(ext_bit_o !== 1'b0);
			chk("ext_cleared", 0, n);
		end
	endtask
	// hang guard
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end
	initial begin
		int len;
		logic [1:0] i2;
		repeat (10) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		wb(1'b0, 8'h7C, 16'h0000);
		chk("general_control", GENERAL_CONTROL_RST, rd);
		wb(1'b0, 8'h94, 16'h0000);
		chk("pattern_control", PATTERN_CONTROL_RST, rd);
		wb(1'b0, 8'h40, 16'h0000);
		chk("unmapped", 0, rd);
		chk("strap_config", 4'hA, strap_config_o);
		$display("test defaults done");
		// each pulse level and single channel, then all channels
		for (int i = 0; i < 4; i++) begin
			i2 = 2'(i);
			wb(1'b1, 8'h94, {4'h0, i2, 3'h0, i2, 5'h00});
			settle();
			chk("pulse_level", exp_level(i2), pulse_level_o);
			chk("channel_mask", 4'h1 << i2, channel_mask_o);
		end
		wb(1'b1, 8'h94, 16'h0480);
		settle();
		chk("channel_mask", 4'hF, channel_mask_o);
		$display("test levels done");
		for (int c = 0; c < 16; c++) begin
			if (c == 6) wb(1'b1, 8'h00, 16'h2000);
			wb(1'b1, 8'h94, 16'h0090 | 16'(c));
			settle();
			chk_kind("tenbt_kind", exp_kind(4'(c)), tenbt_kind_o);
			chk("tenbt_code", {1'b1, 4'(c)}, {tenbt_enable_o, tenbt_code_o});
		end
		$display("test tenbt done");
		run_ext(5'h01);
		run_ext(5'h1F);
		repeat (3) begin
			seed = lfsr(seed);
			run_ext(5'(seed % 31 + 1));
		end
		run_ext(5'h00);
		$display("test pattern done");
		wb(1'b1, 8'h94, 16'h0A60);
		wb(1'b1, 8'h7C, 16'h4123);
		wait_seq(len);
		chk("restart_len", RESTART_HOLD_CYC, len);
		wb(1'b0, 8'h7C, 16'h0000);
		chk("general_control", 16'h0123, rd);
		wb(1'b0, 8'h94, 16'h0000);
		chk("pattern_control", 16'h0A60, rd);
		$display("test restart done");
		strap_i <= 4'h5;
		wb(1'b1, 8'hC0, 16'h0003);
		wb(1'b1, 8'h7C, 16'h8055);
		wait_seq(len);
		chk("reset_len", RESET_HOLD_CYC, len);
		wb(1'b0, 8'h7C, 16'h0000);
		chk("general_control", GENERAL_CONTROL_RST, rd);
		wb(1'b0, 8'h94, 16'h0000);
		chk("pattern_control", PATTERN_CONTROL_RST, rd);
		chk("strap_config", 4'hA, strap_config_o);
		$display("test full reset done");
		report_and_stop();
	end
endmodule

// File: phy_test_pkg.sv
// constants and types for the reset and transmit test pattern control block
// Function
// - full soft reset restores every register default
// - strap-backed fields reload last latched strap values
// - soft restart restarts, registers stay untouched
// - pulse select 00 +2, 01 -2, 10 +1, 11 -1
// - extended 100M pattern: one then N zeros
// - zero count of zero clears pattern shifter
// - extended enable starts 100M one-plus-zeros generator
// - all-channels bit drives pattern onto four channels
// - channel field picks A, B, C or D
// - bit 4 enables 10BASE-T, bits 3:0 pick pattern
// - 10BASE-T codes map to documented pattern kinds
package phy_test_pkg;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 5; // 200 MHz system clock
	localparam int RESET_HOLD_NS = 200; // length of full soft reset
	localparam int RESET_HOLD_CYC = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RESTART_HOLD_NS = 100; // length of soft restart
	localparam int RESTART_HOLD_CYC = (RESTART_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int BIT_PERIOD_NS = 10; // 100M pattern bit time
	localparam int BIT_DIV = BIT_PERIOD_NS / CLK_PERIOD_NS; // clocks per pattern bit
	localparam int SEQ_CNT_W = 8; // sequencer counter width

	// ----------------------------------------
	// register map (index, byte address is 4x)
	// ----------------------------------------
	localparam logic [5:0] IDX_GENERAL_CONTROL = 6'h1F;
	localparam logic [5:0] IDX_PATTERN_CONTROL = 6'h25;
	localparam logic [5:0] IDX_STRAP_CONFIG = 6'h30;
	localparam logic [15:0] GENERAL_CONTROL_RST = 16'h0000;
	localparam logic [15:0] PATTERN_CONTROL_RST = 16'h0480;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int FULL_RESET_BIT = 15;
	localparam int SOFT_RESTART_BIT = 14;
	localparam int PULSE_SEL_LSB = 10; // two bits
	localparam int ZC_MSB_BIT = 9;
	localparam int EXT_EN_BIT = 8;
	localparam int ALL_CH_BIT = 7;
	localparam int CH_SEL_LSB = 5; // two bits
	localparam int TENBT_EN_BIT = 4;
	localparam int ZC_W = 5; // zero count width
	localparam int STRAP_W = 4; // strap-backed field width

	// ----------------------------------------
	// pulse levels, signed amplitude
	// ----------------------------------------
	localparam logic [2:0] LEVEL_P2 = 3'h2;
	localparam logic [2:0] LEVEL_M2 = 3'h6;
	localparam logic [2:0] LEVEL_P1 = 3'h1;
	localparam logic [2:0] LEVEL_M1 = 3'h7;

	// reset and restart sequencer
	typedef enum logic [1:0] {ST_RUN, ST_FULL_RESET, ST_RESTART} seq_state_t;

	// 10BASE-T test pattern kinds
	typedef enum logic [3:0] {
		K_NONE, K_LINK_PULSE, K_PULSE_ONE, K_PULSE_ZERO, K_REP_ONE, K_REP_ZERO,
		K_PREAMBLE, K_ONE_IDLE, K_ZERO_IDLE, K_SEQ_1001, K_RANDOM, K_IDLE_VARIANT
	} tenbt_kind_t;

endpackage
